// file: inc/tmr_pkg.sv
// shared constants and types for the temperature result and status registers
package tmr_pkg;

  // channel count: internal diode on 0, external diodes 1 to 7
  localparam int NUM_CH = 8;

  // avalon byte address width and position of the word index
  localparam int ADDR_W  = 10;
  localparam int IDX_LSB = 2;

  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_STATUS     = 8'h02;
  localparam logic [7:0] IDX_CONFIG     = 8'h03;
  localparam logic [7:0] IDX_RATE       = 8'h04;
  localparam logic [7:0] IDX_CONFIG_ALT = 8'h09;
  localparam logic [7:0] IDX_RATE_ALT   = 8'h0A;
  localparam logic [7:0] IDX_INT  [NUM_CH] = '{8'h00, 8'h01, 8'h23, 8'h2A, 8'h41, 8'h43, 8'h45, 8'h47};
  localparam logic [7:0] IDX_FRAC [NUM_CH] = '{8'h29, 8'h10, 8'h24, 8'h2B, 8'h42, 8'h44, 8'h46, 8'h48};

  // status bit positions
  localparam int ST_BUSY  = 7;
  localparam int ST_HOT   = 6;
  localparam int ST_HIGH  = 4;
  localparam int ST_LOW   = 3;
  localparam int ST_FAULT = 2;
  localparam int ST_CRIT  = 1;
  localparam int ST_HARDWARE_SHUTDOWN_FLAG  = 0;

  // configuration bit positions, writable bits and reset
  localparam int         CFG_MASK    = 7;
  localparam int         CFG_COMP    = 5;
  localparam int         CFG_DAVG    = 1;
  localparam logic [7:0] CFG_WMASK   = 8'hA2;
  localparam logic [7:0] CFG_RESET   = 8'h00;

  // conversion rate codes and reset
  localparam logic [2:0] RATE_RESET = 3'h6;
  localparam logic [2:0] RATE_1     = 3'h4;
  localparam logic [2:0] RATE_2     = 3'h5;
  localparam logic [2:0] RATE_4     = 3'h6;
  localparam logic [2:0] RATE_CONT  = 3'h7;
  localparam logic [4:0] RATE_PAD   = 5'h00;

  // result byte values
  localparam logic [7:0]  FAULT_INT  = 8'h80;
  localparam logic [7:0]  FAULT_FRAC = 8'h00;
  localparam logic [7:0]  FRAC_RESET = 8'h00;
  localparam logic [4:0]  FRAC_PAD   = 5'h00;
  localparam logic [7:0]  RD_NONE    = 8'h00;
  localparam logic [23:0] RD_PAD     = 24'h00_0000;

  // timing: one second window, conversions per second
  localparam int unsigned CLK_HZ        = 32'h02FA_F080;
  localparam int unsigned CONV_WINDOW_S = 32'h0000_0001;
  localparam int unsigned HZ_1          = 32'h0000_0001;
  localparam int unsigned HZ_2          = 32'h0000_0002;
  localparam int unsigned HZ_4          = 32'h0000_0004;
  localparam int unsigned HZ_C4         = 32'h0000_000C;
  localparam int unsigned HZ_C5         = 32'h0000_000B;
  localparam int unsigned HZ_C6         = 32'h0000_000A;
  localparam int unsigned HZ_C7         = 32'h0000_0009;
  localparam logic [2:0]  EXT_5         = 3'h5;
  localparam logic [2:0]  EXT_6         = 3'h6;
  localparam logic [2:0]  EXT_7         = 3'h7;

  // averaging factor codes
  localparam logic [2:0] AVG_LOW = 3'h0;
  localparam logic [2:0] AVG_X1  = 3'h1;
  localparam logic [2:0] AVG_X2  = 3'h2;
  localparam logic [2:0] AVG_X4  = 3'h3;
  localparam logic [2:0] AVG_X8  = 3'h4;

  typedef struct packed {
    logic [7:0] whole;
    logic [2:0] frac;
  } tmr_temp_t;

  typedef struct packed {
    logic high;
    logic low;
    logic crit;
  } tmr_hit_t;

  typedef struct packed {
    logic high;
    logic low;
    logic fault;
    logic crit;
  } tmr_clr_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } tmr_bus_t;

endpackage

// file: verif/tb_top.sv
// testbench for the temperature result and status registers
`timescale 1ns/100ps
module tb_top
  import tmr_pkg::*;
;
  localparam int SEC = 3960;
  logic                    ref_clk = 1'b0;
  logic                    reset_n = 1'b0;
  logic [ADDR_W-1:0]       avs_address = '0;
  logic                    avs_read = 1'b0;
  logic                    avs_write = 1'b0;
  logic [31:0]             avs_writedata = '0;
  logic [3:0]              avs_byteenable = 4'hF;
  logic [31:0]             avs_readdata;
  logic                    avs_waitrequest;
  tmr_temp_t [NUM_CH-1:0]  chanResult;
  tmr_temp_t [NUM_CH-1:0]  setRes = '0;
  logic [NUM_CH-1:0]       chanFault;
  logic [NUM_CH-1:0]       setFault = '0;
  logic                    convBusy;
  logic [2:0]              enabledExtCount = 3'h7;
  tmr_hit_t                limitHit = '0;
  tmr_clr_t                limitClear = '0;
  logic                    hottestChanged = 1'b0;
  logic                    hottestReportEnable = 1'b0;
  logic                    shutdownActive = 1'b0;
  logic                    alertN, shutdownOutput, hysteresisEnable, convStart;
  logic [2:0]              avgCode;
  int                      fail_count = 0;
  int                      n_checks = 0;
  int                      cyc = 0;
  logic [2:0]              codes [5] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
  int                      pers  [5] = '{SEC, SEC / 2, SEC / 4, SEC / 9, SEC / 4};
  logic [2:0]              avgOn [5] = '{3'h4, 3'h3, 3'h2, 3'h1, 3'h2};
  logic [2:0]              avgOff [5] = '{3'h1, 3'h1, 3'h1, 3'h0, 3'h1};

  tmr_regs #(.SEC_CYCLES(SEC)) uut (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chanResult(chanResult),
    .chanFault(chanFault), .convBusy(convBusy), .enabledExtCount(enabledExtCount), .limitHit(limitHit),
    .limitClear(limitClear), .hottestChanged(hottestChanged), .hottestReportEnable(hottestReportEnable),
    .shutdownActive(shutdownActive), .alertN(alertN), .shutdownOutput(shutdownOutput),
    .hysteresisEnable(hysteresisEnable), .convStart(convStart), .avgCode(avgCode));
  tmr_conv_model model (.ref_clk(ref_clk), .reset_n(reset_n), .convStart(convStart), .setRes(setRes),
    .setFault(setFault), .chanResult(chanResult), .chanFault(chanFault), .convBusy(convBusy));

  initial forever #10 ref_clk = ~ref_clk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one avalon transfer: hold until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] be,
                     output logic [31:0] rd);
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h00_0000, wd};
    avs_byteenable <= be;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    bus(1'b0, idx, 8'h00, 4'hF, d);
    chk(d, {24'h00_0000, exp});
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v, input logic [3:0] be = 4'hF);
    logic [31:0] d;
    bus(1'b1, idx, v, be, d);
  endtask

  task automatic conv();
    @(posedge ref_clk iff convStart);
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic pulse(input tmr_hit_t h, input tmr_clr_t c);
    @(posedge ref_clk);
    limitHit <= h;
    limitClear <= c;
    @(posedge ref_clk);
    limitHit <= '0;
    limitClear <= '0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic measure(input int exp);
    int c;
    c = 0;
    @(posedge ref_clk iff convStart);
    @(posedge ref_clk iff convStart);
    do
    begin
      @(posedge ref_clk);
      c++;
    end
    while (convStart !== 1'b1);
    chk(c, exp);
  endtask

  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    rdchk(8'h03, 8'h00);
    rdchk(8'h04, 8'h06);
    rdchk(8'h0A, 8'h06);
    rdchk(8'hFF, 8'h00);
    wr(8'h01, 8'h55);
    rdchk(8'h01, 8'h00);
    wr(8'h09, 8'hFF);
    rdchk(8'h03, 8'hA2);
    wr(8'h03, 8'h00, 4'hE);
    rdchk(8'h09, 8'hA2);
    wr(8'h0A, 8'hFF);
    rdchk(8'h04, 8'h07);
    wr(8'h03, 8'h00);
    wr(8'h04, 8'h06);
    @(posedge ref_clk iff convStart);
    rdchk(8'h02, 8'h80);
    chk(alertN, 1'b1);
    $display("test registers done");
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h04, {5'h00, codes[i]});
      measure(pers[i]);
      chk(avgCode, avgOn[i]);
      wr(8'h09, 8'h02);
      repeat (2) @(posedge ref_clk);
      chk(avgCode, avgOff[i]);
      wr(8'h09, 8'h00);
    end
    wr(8'h04, 8'h07);
    enabledExtCount <= 3'h4;
    measure(SEC / 12);
    wr(8'h04, 8'h06);
    $display("test rate done");
    for (int ch = 0; ch < NUM_CH; ch++)
      setRes[ch] <= '{(ch == 0) ? 8'h7F : (8'hC0 | 8'(ch)), 3'(ch)};
    conv();
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      rdchk(IDX_INT[ch], (ch == 0) ? 8'h7F : (8'hC0 | 8'(ch)));
      rdchk(IDX_FRAC[ch], {3'(ch), 5'h00});
    end
    setRes[1] <= '{8'h19, 3'h5};
    conv();
    rdchk(8'h01, 8'h19);
    setRes[1] <= '{8'h1A, 3'h2};
    conv();
    rdchk(8'h10, 8'hA0);
    rdchk(8'h01, 8'h1A);
    setRes[1] <= '{8'h1B, 3'h7};
    conv();
    rdchk(8'h01, 8'h1B);
    rdchk(8'h10, 8'hE0);
    $display("test results done");
    for (int k = 0; k < 3; k++)
    begin
      pulse(3'b100 >> k, '0);
      chk(alertN, k == 2);
      rdchk(8'h02, (k == 0) ? 8'h10 : (k == 1) ? 8'h08 : 8'h02);
      pulse('0, (k == 2) ? 4'b0001 : (4'b1000 >> k));
      rdchk(8'h02, 8'h00);
    end
    pulse(3'b100, '0);
    wr(8'h03, 8'h80);
    repeat (3) @(posedge ref_clk);
    chk(alertN, 1'b1);
    rdchk(8'h02, 8'h10);
    wr(8'h03, 8'hA0);
    pulse(3'b100, '0);
    chk(alertN, 1'b0);
    chk(hysteresisEnable, 1'b1);
    pulse('0, 4'b1000);
    wr(8'h03, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk(alertN, 1'b1);
    @(posedge ref_clk);
    hottestChanged <= 1'b1;
    @(posedge ref_clk);
    hottestChanged <= 1'b0;
    rdchk(8'h02, 8'h00);
    hottestReportEnable <= 1'b1;
    hottestChanged <= 1'b1;
    @(posedge ref_clk);
    hottestChanged <= 1'b0;
    rdchk(8'h02, 8'h40);
    rdchk(8'h02, 8'h00);
    shutdownActive <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(shutdownOutput, 1'b1);
    rdchk(8'h02, 8'h01);
    rdchk(8'h02, 8'h01);
    shutdownActive <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rdchk(8'h02, 8'h01);
    rdchk(8'h02, 8'h00);
    $display("test status done");
    setFault <= 8'h01;
    conv();
    rdchk(8'h02, 8'h00);
    setFault <= 8'h02;
    conv();
    rdchk(8'h01, 8'h80);
    rdchk(8'h10, 8'h00);
    rdchk(8'h02, 8'h04);
    chk(alertN, 1'b0);
    $display("test fault done");
    close_out();
  end
endmodule

// file: verif/tmr_conv_model.sv
// converter model: busy after each start, then loads the staged results
`timescale 1ns/100ps
module tmr_conv_model
  import tmr_pkg::*;
#(
  parameter int BUSY_CYC = 4
)
(
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   reset_n,
  // start and staged values
  input wire logic                   convStart,
  input wire tmr_temp_t [NUM_CH-1:0] setRes,
  input wire logic [NUM_CH-1:0]      setFault,
  // converter outputs
  output tmr_temp_t [NUM_CH-1:0]     chanResult,
  output logic [NUM_CH-1:0]          chanFault,
  output logic                       convBusy
);
  int cnt;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt <= 0;
      convBusy <= 1'b0;
      chanResult <= '0;
      chanFault <= '0;
    end
    else if (convStart)
    begin
      cnt <= BUSY_CYC;
      convBusy <= 1'b1;
    end
    else if (cnt == 1)
    begin
      cnt <= 0;
      convBusy <= 1'b0;
      chanResult <= setRes;
      chanFault <= setFault;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule

// file: verif/tmr_regs_properties.sv
// concurrent checks on the register block ports
`timescale 1ns/100ps
module tmr_regs_properties
  import tmr_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = CLK_HZ * CONV_WINDOW_S
)
(
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   reset_n,
  // bus
  input wire logic [ADDR_W-1:0]      avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  // converter and limits
  input wire tmr_temp_t [NUM_CH-1:0] chanResult,
  input wire logic [NUM_CH-1:0]      chanFault,
  input wire tmr_hit_t               limitHit,
  input wire logic                   shutdownActive,
  // outputs
  input wire logic                   alertN,
  input wire logic                   shutdownOutput,
  input wire logic                   hysteresisEnable,
  input wire logic                   convStart
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not low for one cycle");
  AST_RD_PAD: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  AST_UNMAPPED: assert property (avs_read && avs_waitrequest && avs_address[9:2] == 8'hFF |=> avs_readdata == '0)
    else $error("unmapped read not zero");
  AST_INT_RD: assert property (avs_read && avs_waitrequest && avs_address[9:2] == IDX_INT[1] && !chanFault[1]
    |=> avs_readdata[7:0] == $past(chanResult[1].whole))
    else $error("integer byte wrong");
  AST_FAULT_RD: assert property (avs_read && avs_waitrequest && avs_address[9:2] == IDX_INT[1] && chanFault[1]
    |=> avs_readdata[7:0] == 8'h80)
    else $error("fault integer byte wrong");
  AST_SHUT_SET: assert property (shutdownActive |=> shutdownOutput)
    else $error("shutdown output not driven");
  AST_SHUT_FALL: assert property ($fell(shutdownActive) |=> !shutdownOutput)
    else $error("shutdown output not released");
  AST_ALERT_COMP: assert property (limitHit.high && hysteresisEnable && $past(hysteresisEnable) |-> ##2 !alertN)
    else $error("comparator alert missing");
  AST_CFG_WRITE: assert property ($rose(hysteresisEnable) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("mode changed without write");
  AST_CONV_PULSE: assert property (convStart |=> !convStart)
    else $error("conversion start too long");
  cover property (avs_read && !avs_waitrequest && avs_address[9:2] == IDX_FRAC[1]);
  cover property (convStart);
  cover property ($fell(alertN));
  cover property ($rose(shutdownOutput));
endmodule
bind tmr_regs tmr_regs_properties #(.SEC_CYCLES(SEC_CYCLES)) u_props (.ref_clk(ref_clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .chanResult(chanResult), .chanFault(chanFault), .limitHit(limitHit),
  .shutdownActive(shutdownActive), .alertN(alertN), .shutdownOutput(shutdownOutput),
  .hysteresisEnable(hysteresisEnable), .convStart(convStart));

// file: verilog/tmr_regs.sv
// temperature result, status, configuration and rate registers behind an avalon-mm slave
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/100ps
module tmr_regs
  import tmr_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = CLK_HZ * CONV_WINDOW_S
)
(
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]        avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  // converter side
  input  wire tmr_temp_t [NUM_CH-1:0]   chanResult,
  input  wire logic [NUM_CH-1:0]        chanFault,
  input  wire logic                     convBusy,
  input  wire logic [2:0]               enabledExtCount,
  // limit comparison side
  input  wire tmr_hit_t                 limitHit,
  input  wire tmr_clr_t                 limitClear,
  input  wire logic                     hottestChanged,
  input  wire logic                     hottestReportEnable,
  input  wire logic                     shutdownActive,
  // outputs
  output logic                          alertN,
  output logic                          shutdownOutput,
  output logic                          hysteresisEnable,
  output logic                          convStart,
  output logic [2:0]                    avgCode
);

  localparam int CNT_W = $clog2(SEC_CYCLES + 1);
  localparam int unsigned LAST_1  = SEC_CYCLES / HZ_1 - 1;
  localparam int unsigned LAST_2  = SEC_CYCLES / HZ_2 - 1;
  localparam int unsigned LAST_4  = SEC_CYCLES / HZ_4 - 1;
  localparam int unsigned LAST_C4 = SEC_CYCLES / HZ_C4 - 1;
  localparam int unsigned LAST_C5 = SEC_CYCLES / HZ_C5 - 1;
  localparam int unsigned LAST_C6 = SEC_CYCLES / HZ_C6 - 1;
  localparam int unsigned LAST_C7 = SEC_CYCLES / HZ_C7 - 1;

  tmr_bus_t          busState;
  logic [7:0]        regIdx;
  logic              busReq;
  logic              sample;
  logic              accept;
  logic              statusClr;
  logic              cfgHit;
  logic              rateHit;
  logic              wrLow;
  logic [7:0]        readByte;
  logic [7:0]        statusByte;
  logic [7:0]        deviceConfig;
  logic [2:0]        rateCode;
  logic              hotFlag;
  logic              highFlag;
  logic              lowFlag;
  logic              faultFlag;
  logic              critFlag;
  logic              hwsdFlag;
  logic [NUM_CH-1:0] intHit;
  logic [NUM_CH-1:0] fracHit;
  logic [7:0]        intByte [NUM_CH];
  logic [7:0]        fracByte [NUM_CH];
  logic [7:0]        shadow [NUM_CH];
  logic [CNT_W-1:0]  convCnt;
  logic [CNT_W-1:0]  lastCount;
  logic [CNT_W-1:0]  contLast;
  logic [2:0]        avgDyn;
  logic [2:0]        avgFix;
  logic [2:0]        next_avgCode;
  logic              alertCond;

  // bus decode: answer formed on the first edge, effects on the second
  assign regIdx    = avs_address[ADDR_W-1:IDX_LSB];
  assign busReq    = avs_read | avs_write;
  assign sample    = busReq & (busState == BUS_IDLE);
  assign accept    = busReq & (busState == BUS_DONE);
  assign cfgHit    = (regIdx == IDX_CONFIG) | (regIdx == IDX_CONFIG_ALT);
  assign rateHit   = (regIdx == IDX_RATE) | (regIdx == IDX_RATE_ALT);
  assign wrLow     = avs_write & avs_byteenable[0] & accept;
  assign statusClr = avs_read & accept & (regIdx == IDX_STATUS);

  // per channel result bytes and low byte shadow
  generate
    for (genvar ch = 0; ch < NUM_CH; ch++)
    begin : g_chan
      assign intHit[ch]  = (regIdx == IDX_INT[ch]);
      assign fracHit[ch] = (regIdx == IDX_FRAC[ch]);
      // two's complement integer passes as is, fraction left justified
      assign intByte[ch]  = chanFault[ch] ? FAULT_INT : chanResult[ch].whole;
      assign fracByte[ch] = chanFault[ch] ? FAULT_FRAC
                                          : {chanResult[ch].frac, FRAC_PAD};

      // captured on the same edge that latches the integer byte for the bus
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
          shadow[ch] <= FRAC_RESET;
        else if (sample && avs_read && intHit[ch])
          shadow[ch] <= fracByte[ch];
      end
    end
  endgenerate

  // status byte as software sees it
  always_comb
  begin
    statusByte           = RD_NONE;
    statusByte[ST_BUSY]  = convBusy;
    statusByte[ST_HOT]   = hotFlag;
    statusByte[ST_HIGH]  = highFlag;
    statusByte[ST_LOW]   = lowFlag;
    statusByte[ST_FAULT] = faultFlag;
    statusByte[ST_CRIT]  = critFlag;
    statusByte[ST_HARDWARE_SHUTDOWN_FLAG]  = hwsdFlag;
  end

  // read multiplexer; unmapped indexes read zero
  always_comb
  begin
    readByte = RD_NONE;
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      if (intHit[ch])
        readByte = intByte[ch];
      if (fracHit[ch])
        readByte = shadow[ch];
    end
    if (regIdx == IDX_STATUS)
      readByte = statusByte;
    if (cfgHit)
      readByte = deviceConfig;
    if (rateHit)
      readByte = {RATE_PAD, rateCode};
  end

  // avalon handshake: one wait cycle, then waitrequest low for one cycle
  // read data is latched on the first edge, the one that drops waitrequest, the same edge that fills the shadow
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busState        <= BUS_IDLE;
      avs_waitrequest <= '1;
      avs_readdata    <= '0;
    end
    else
    begin
      unique case (busState)
        BUS_IDLE:
        begin
          if (busReq)
          begin
            busState        <= BUS_DONE;
            avs_waitrequest <= '0;
            avs_readdata    <= {RD_PAD, readByte};
          end
        end
        BUS_DONE:
        begin
          busState        <= BUS_IDLE;
          avs_waitrequest <= '1;
        end
      endcase
    end
  end

  // configuration storage, shared by both addresses
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      deviceConfig <= CFG_RESET;
    else if (wrLow && cfgHit)
      deviceConfig <= avs_writedata[7:0] & CFG_WMASK;
  end

  // conversion rate storage, shared by both addresses
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rateCode <= RATE_RESET;
    else if (wrLow && rateHit)
      rateCode <= avs_writedata[2:0];
  end

  // sticky status bits; a set in the clearing cycle wins, and a read
  // only clears what it actually returned
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      hotFlag <= '0;
    else
      hotFlag <= (hottestChanged & hottestReportEnable)
               | (hotFlag & ~(statusClr & avs_readdata[ST_HOT]));
  end

  // limit flags: set from the comparators, cleared by a limit status access
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      highFlag <= '0;
    else
      highFlag <= limitHit.high | (highFlag & ~limitClear.high);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      lowFlag <= '0;
    else
      lowFlag <= limitHit.low | (lowFlag & ~limitClear.low);
  end

  // the internal diode has no fault report, so only external channels count
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      faultFlag <= '0;
    else
      faultFlag <= (|chanFault[NUM_CH-1:1])
                 | (faultFlag & ~limitClear.fault);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      critFlag <= '0;
    else
      critFlag <= limitHit.crit | (critFlag & ~limitClear.crit);
  end

  // shutdown flag may only be read away once the output has let go
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      shutdownOutput <= '0;
    else
      shutdownOutput <= shutdownActive;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      hwsdFlag <= '0;
    else
      hwsdFlag <= shutdownActive
                | (hwsdFlag & ~(statusClr & avs_readdata[ST_HARDWARE_SHUTDOWN_FLAG] & ~shutdownOutput));
  end

  // alert: busy, hottest, critical and shutdown bits take no part
  assign alertCond = highFlag | lowFlag | faultFlag;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      alertN <= '1;
    else
      alertN <= ~(alertCond & (deviceConfig[CFG_COMP] | ~deviceConfig[CFG_MASK]));
  end

  // limit comparators add hysteresis on high limits in comparator mode
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      hysteresisEnable <= '0;
    else
      hysteresisEnable <= deviceConfig[CFG_COMP];
  end

  // continuous period depends on how many external channels are enabled
  always_comb
  begin
    case (enabledExtCount)
      EXT_5:   contLast = CNT_W'(LAST_C5);
      EXT_6:   contLast = CNT_W'(LAST_C6);
      EXT_7:   contLast = CNT_W'(LAST_C7);
      default: contLast = CNT_W'(LAST_C4);
    endcase
  end

  // period and averaging per rate code; unlisted codes behave as 4 per second
  always_comb
  begin
    case (rateCode)
      RATE_1:
      begin
        lastCount = CNT_W'(LAST_1);
        avgDyn    = AVG_X8;
        avgFix    = AVG_X1;
      end
      RATE_2:
      begin
        lastCount = CNT_W'(LAST_2);
        avgDyn    = AVG_X4;
        avgFix    = AVG_X1;
      end
      RATE_CONT:
      begin
        lastCount = contLast;
        avgDyn    = AVG_X1;
        avgFix    = AVG_LOW;
      end
      default:
      begin
        lastCount = CNT_W'(LAST_4);
        avgDyn    = AVG_X2;
        avgFix    = AVG_X1;
      end
    endcase
    next_avgCode = deviceConfig[CFG_DAVG] ? avgFix : avgDyn;
  end

  // conversion pacing: one start pulse per period
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      convCnt   <= '0;
      convStart <= '0;
    end
    else if (convCnt >= lastCount)
    begin
      convCnt   <= '0;
      convStart <= '1;
    end
    else
    begin
      convCnt   <= convCnt + CNT_W'(1);
      convStart <= '0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      avgCode <= AVG_X2;
    else
      avgCode <= next_avgCode;
  end

endmodule
